// ---- hw/alarm_pkg.sv ----
package alarm_pkg;

  // ------------------------------------------------------------
  // bus shape and register offsets
  // ------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] WINDOW_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;

  // ------------------------------------------------------------
  // control and status fields
  // ------------------------------------------------------------
  localparam int UNLOCK_BIT = 0;
  localparam int PTR_LSB = 8;
  localparam int PTR_W = 2;
  localparam int REFUSED_BIT = 0;
  localparam int RANGE_BIT = 1;
  localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
  localparam logic [1:0] PTR_WEEKDAY_DIGIT_HOUR = 2'h1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] VIEW_RESET = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h0301;
  localparam logic [15:0] STATUS_MASK = 16'h0003;

  // ------------------------------------------------------------
  // digit fields of the two views
  // ------------------------------------------------------------
  localparam int MTEN_BIT = 12;
  localparam int MONE_LSB = 8;
  localparam int WEEKDAY_DIGIT_LSB = 8;
  localparam int TEN_LSB = 4;
  localparam int ONE_LSB = 0;
  localparam logic [15:0] MD_MASK = 16'h1f3f;
  localparam logic [15:0] WH_MASK = 16'h073f;
  localparam logic [3:0] ONES_MAX = 4'h9;
  localparam logic [1:0] DAY_TENS_MAX = 2'h3;
  localparam logic [1:0] HOUR_TENS_MAX = 2'h2;
  localparam logic [2:0] WEEKDAY_DIGIT_MAX = 3'h6;

  typedef enum logic [2:0] {
    VIEW_NONE = 3'b001,
    VIEW_MD = 3'b010,
    VIEW_WH = 3'b100
  } view_t;

  function automatic view_t decode_view(input logic [1:0] ptr);
    case (ptr)
      PTR_MONTH_DAY: decode_view = VIEW_MD;
      PTR_WEEKDAY_DIGIT_HOUR: decode_view = VIEW_WH;
      default: decode_view = VIEW_NONE;
    endcase
  endfunction

endpackage

// ---- hw/view_if.sv ----
`timescale 1ns/1ps
interface view_if;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] q;

  modport owner (
    output wr,
    output wdata,
    input q
  );

  modport store (
    input wr,
    input wdata,
    output q
  );
endinterface

// ---- hw/alarm_view_store.sv ----
`timescale 1ns/1ps
module alarm_view_store #(
  parameter logic [15:0] MASK = 16'hffff
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side and stored view
  view_if.store port
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // unused positions are never stored, so they read back as zero
  logic [15:0] value;
  wire logic [15:0] next_value = port.wdata & MASK;

  always_ff @(posedge clk)
  begin
    if (rst)
      value <= alarm_pkg::VIEW_RESET;
    else if (port.wr)
      value <= next_value;
  end

  assign port.q = value;

endmodule

// ---- hw/alarm_bcd_check.sv ----
`timescale 1ns/1ps
module alarm_bcd_check (
  // view and candidate word
  input wire alarm_pkg::view_t view,
  input wire logic [15:0] data,
  // verdict
  output logic ok
);

  // ------------------------------------------------------------
  // per-digit limits
  // ------------------------------------------------------------
  wire logic [3:0] hi_ones = data[11:8];
  wire logic [1:0] tens = data[5:4];
  wire logic [3:0] ones = data[3:0];
  wire logic [2:0] weekday_digit = data[10:8];
  wire logic ones_ok = ones <= alarm_pkg::ONES_MAX;
  wire logic md_ok = (hi_ones <= alarm_pkg::ONES_MAX)
                     && (tens <= alarm_pkg::DAY_TENS_MAX) && ones_ok;
  wire logic wh_ok = (weekday_digit <= alarm_pkg::WEEKDAY_DIGIT_MAX)
                     && (tens <= alarm_pkg::HOUR_TENS_MAX) && ones_ok;

  always_comb
  begin
    case (view)
      alarm_pkg::VIEW_MD: ok = md_ok;
      alarm_pkg::VIEW_WH: ok = wh_ok;
      default: ok = 1'b0;
    endcase
  end

endmodule

// ---- hw/alarm_value_window.sv ----
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
// Behaviour
// RL1: pointer 10 maps the window onto the month and day view.
// RL2: pointer 01 maps the window onto the weekday and hour view.
// RL3: month tens digit is one read-write bit at position 12.
// RL4: month ones digit is read-write in bits 11 to 8, 0 to 9.
// RL5: day tens digit is read-write in bits 5 to 4, 0 to 3.
// RL6: day ones digit is read-write in bits 3 to 0, 0 to 9.
// RL7: weekday is read-write in bits 10 to 8, 0 to 6.
// RL8: hour tens digit is read-write in bits 5 to 4, 0 to 2.
// RL9: hour ones digit is read-write in bits 3 to 0, 0 to 9.
// RL10: window writes take effect only while the write unlock bit is 1.
// RL11: unused bit positions of both views read as zero.
// RL12: a window write while locked is ignored; digits stay unchanged.
module alarm_value_window #(
  parameter int DATA_W = alarm_pkg::DATA_W
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // control state
  output logic CLOCK_WRITE_UNLOCK,
  output logic [1:0] ALARM_VIEW_POINTER,
  // stored alarm digits
  output logic MONTH_TENS_DIGIT,
  output logic [3:0] MONTH_ONES_DIGIT,
  output logic [1:0] DAY_TENS_DIGIT,
  output logic [3:0] DAY_ONES_DIGIT,
  output logic [2:0] WEEKDAY_DIGIT,
  output logic [1:0] HOUR_TENS_DIGIT,
  output logic [3:0] HOUR_ONES_DIGIT
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  // the digit layout is fixed to a 16-bit word
  generate
    if (DATA_W != 16)
    begin : g_bad_width
      $error("alarm_value_window serves only DATA_W of 16");
    end
    // the checks below guard the package layout: a field that slips
    // onto a neighbour would let one digit overwrite another
    if (alarm_pkg::PTR_LSB + alarm_pkg::PTR_W > DATA_W)
    begin : g_bad_ptr
      $error("pointer field does not fit the control word");
    end
    if (alarm_pkg::PTR_MONTH_DAY == alarm_pkg::PTR_WEEKDAY_DIGIT_HOUR)
    begin : g_bad_codes
      $error("both pointer codes select the same view");
    end
    if (alarm_pkg::CTRL_MASK[alarm_pkg::UNLOCK_BIT] == 1'b0)
    begin : g_bad_unlock
      $error("unlock bit is missing from the control mask");
    end
    if (alarm_pkg::CTRL_MASK[alarm_pkg::PTR_LSB] == 1'b0)
    begin : g_bad_ptr_mask
      $error("pointer field is missing from the control mask");
    end
    if (alarm_pkg::REFUSED_BIT == alarm_pkg::RANGE_BIT)
    begin : g_bad_flags
      $error("status flags share one position");
    end
    if (alarm_pkg::STATUS_MASK[alarm_pkg::REFUSED_BIT] == 1'b0
        || alarm_pkg::STATUS_MASK[alarm_pkg::RANGE_BIT] == 1'b0)
    begin : g_bad_status
      $error("a status flag is missing from the status mask");
    end
    if (alarm_pkg::MTEN_BIT >= DATA_W
        || alarm_pkg::MONE_LSB + 4 > alarm_pkg::MTEN_BIT)
    begin : g_bad_month
      $error("month digits overlap or leave the word");
    end
    if (alarm_pkg::WEEKDAY_DIGIT_LSB + 3 > DATA_W)
    begin : g_bad_weekday_digit
      $error("weekday field does not fit the word");
    end
    if (alarm_pkg::ONE_LSB + 4 > alarm_pkg::TEN_LSB
        || alarm_pkg::TEN_LSB + 2 > alarm_pkg::MONE_LSB
        || alarm_pkg::TEN_LSB + 2 > alarm_pkg::WEEKDAY_DIGIT_LSB)
    begin : g_bad_low
      $error("tens and ones digits overlap");
    end
    if (alarm_pkg::MD_MASK[alarm_pkg::MTEN_BIT] == 1'b0
        || alarm_pkg::WH_MASK[alarm_pkg::WEEKDAY_DIGIT_LSB + 2] == 1'b0)
    begin : g_bad_mask
      $error("a view mask leaves out a digit bit");
    end
    if (alarm_pkg::ONES_MAX > 4'h9)
    begin : g_bad_ones
      $error("a decimal ones digit cannot pass nine");
    end
  endgenerate

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // an address outside the three words selects nothing, so unmapped
  // writes fall away and unmapped reads answer zero
  wire logic ctrl_sel = ADDR == alarm_pkg::CTRL_OFS;
  wire logic window_sel = ADDR == alarm_pkg::WINDOW_OFS;
  wire logic status_sel = ADDR == alarm_pkg::STATUS_OFS;
  wire logic mapped = ctrl_sel || window_sel || status_sel;
  wire logic ctrl_wr = WR && ctrl_sel;
  wire logic window_wr = WR && window_sel;
  wire logic status_wr = WR && status_sel;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic [15:0] ctrl;
  // a control write lands at the next edge, so a window write in the
  // following cycle already sees the new unlock and pointer
  wire logic [15:0] next_ctrl = WDATA & alarm_pkg::CTRL_MASK;
  wire logic unlock = ctrl[alarm_pkg::UNLOCK_BIT];
  wire logic [1:0] ptr = ctrl[alarm_pkg::PTR_LSB +: alarm_pkg::PTR_W];

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      ctrl <= alarm_pkg::CTRL_RESET;
    else if (ctrl_wr)
      ctrl <= next_ctrl;
  end

  assign CLOCK_WRITE_UNLOCK = unlock;
  assign ALARM_VIEW_POINTER = ptr;

  // ------------------------------------------------------------
  // view selection
  // ------------------------------------------------------------
  // pointer codes 00 and 11 select no view: reads give zero and
  // writes are dropped, so no digit can be hit by accident
  alarm_pkg::view_t view;
  assign view = alarm_pkg::decode_view(ptr); // see RL1 see RL2
  wire logic view_md = view == alarm_pkg::VIEW_MD;
  wire logic view_wh = view == alarm_pkg::VIEW_WH;
  wire logic view_none = view == alarm_pkg::VIEW_NONE;

  // ------------------------------------------------------------
  // digit range check
  // ------------------------------------------------------------
  // only the word on the bus is checked; stored digits stay in range
  // because nothing else can reach the view flops
  logic range_ok;

  alarm_bcd_check u_check (
    .view(view),
    .data(WDATA),
    .ok(range_ok)
  );

  // ------------------------------------------------------------
  // write acceptance
  // ------------------------------------------------------------
  // a locked write leaves the stored digits alone
  wire logic locked_wr = window_wr && !unlock; // see RL12
  wire logic open_wr = window_wr && unlock && !view_none; // see RL10
  // a digit outside its decimal range is refused whole, so a view
  // never holds a mix of old and new digits
  wire logic bad_wr = open_wr && !range_ok;
  wire logic accept = open_wr && range_ok;
  wire logic md_wr = accept && view_md; // see RL1
  wire logic wh_wr = accept && view_wh; // see RL2

  // ------------------------------------------------------------
  // view storage
  // ------------------------------------------------------------
  // each view keeps flops of its own, so moving the pointer never
  // loses the digits of the view that is not shown
  view_if vif[2] ();

  assign vif[0].wr = md_wr;
  assign vif[0].wdata = WDATA;
  assign vif[1].wr = wh_wr;
  assign vif[1].wdata = WDATA;

  // only the documented digit positions hold flops
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_view
      localparam logic [15:0] MASK =
        (gi == 0) ? alarm_pkg::MD_MASK : alarm_pkg::WH_MASK; // see RL11
      alarm_view_store #(
        .MASK(MASK)
      ) u_store (
        .clk(CORE_CLK),
        .rst(RESET),
        .port(vif[gi])
      );
    end
  endgenerate

  wire logic [15:0] md_q = vif[0].q;
  wire logic [15:0] wh_q = vif[1].q;

  // ------------------------------------------------------------
  // digit outputs
  // ------------------------------------------------------------
  // digits come straight from the view flops, so they move only on
  // an accepted write; tens and ones share their places in both views
  function automatic logic [1:0] tens_of(input logic [15:0] word);
    tens_of = word[alarm_pkg::TEN_LSB +: 2];
  endfunction

  function automatic logic [3:0] ones_of(input logic [15:0] word);
    ones_of = word[alarm_pkg::ONE_LSB +: 4];
  endfunction

  assign MONTH_TENS_DIGIT = md_q[alarm_pkg::MTEN_BIT]; // see RL3
  assign MONTH_ONES_DIGIT =
    md_q[alarm_pkg::MONE_LSB +: 4]; // see RL4
  assign DAY_TENS_DIGIT = tens_of(md_q); // see RL5
  assign DAY_ONES_DIGIT = ones_of(md_q); // see RL6
  assign WEEKDAY_DIGIT = wh_q[alarm_pkg::WEEKDAY_DIGIT_LSB +: 3]; // see RL7
  assign HOUR_TENS_DIGIT = tens_of(wh_q); // see RL8
  assign HOUR_ONES_DIGIT = ones_of(wh_q); // see RL9

  // ------------------------------------------------------------
  // window read view
  // ------------------------------------------------------------
  // masking again on the read side keeps unused positions at zero
  // even if a store were ever built with a wider mask
  logic [15:0] window_word;

  always_comb
  begin
    case (view)
      alarm_pkg::VIEW_MD: window_word = md_q & alarm_pkg::MD_MASK;
      alarm_pkg::VIEW_WH: window_word = wh_q & alarm_pkg::WH_MASK;
      default: window_word = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // status register
  // ------------------------------------------------------------
  // sticky flags, cleared by writing one; a new event in the same
  // cycle as its clear keeps the flag set
  logic refused;
  logic range_err;
  wire logic clr_refused = status_wr && WDATA[alarm_pkg::REFUSED_BIT];
  wire logic clr_range = status_wr && WDATA[alarm_pkg::RANGE_BIT];
  wire logic next_refused = locked_wr || (refused && !clr_refused);
  wire logic next_range = bad_wr || (range_err && !clr_range);

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      refused <= 1'b0;
      range_err <= 1'b0;
    end
    else
    begin
      refused <= next_refused;
      range_err <= next_range;
    end
  end

  // the flags live apart from the views, so polling them never
  // disturbs the alarm digits
  logic [15:0] status_word;

  always_comb
  begin
    status_word = 16'h0000;
    status_word[alarm_pkg::REFUSED_BIT] = refused;
    status_word[alarm_pkg::RANGE_BIT] = range_err;
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // an unmapped read answers zero; data stand for as many cycles as RD is held, one cycle later
  logic [15:0] read_word;

  always_comb
  begin
    read_word = 16'h0000;
    if (ctrl_sel)
      read_word = ctrl & alarm_pkg::CTRL_MASK;
    else if (window_sel)
      read_word = window_word; // see RL11
    else if (status_sel)
      read_word = status_word & alarm_pkg::STATUS_MASK;
  end

  // zero outside reads keeps stale words off the bus
  wire logic [15:0] next_rdata = (RD && mapped) ? read_word : 16'h0000;

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      RDATA <= 16'h0000;
    else
      RDATA <= next_rdata;
  end

endmodule

// ---- tb/alarm_value_window_checker.sv ----
`timescale 1ns/1ps
module alarm_value_window_checker (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // control and digits
  input wire logic CLOCK_WRITE_UNLOCK,
  input wire logic [1:0] ALARM_VIEW_POINTER,
  input wire logic MONTH_TENS_DIGIT,
  input wire logic [3:0] MONTH_ONES_DIGIT,
  input wire logic [1:0] DAY_TENS_DIGIT,
  input wire logic [3:0] DAY_ONES_DIGIT,
  input wire logic [2:0] WEEKDAY_DIGIT,
  input wire logic [1:0] HOUR_TENS_DIGIT,
  input wire logic [3:0] HOUR_ONES_DIGIT
);
  logic [15:0] wd_q;
  wire win = (ADDR == alarm_pkg::WINDOW_OFS);
  wire win_wr = WR && win;
  wire is_md = (ALARM_VIEW_POINTER == alarm_pkg::PTR_MONTH_DAY);
  wire is_wh = (ALARM_VIEW_POINTER == alarm_pkg::PTR_WEEKDAY_DIGIT_HOUR);
  wire [15:0] md_view = {3'h0, MONTH_TENS_DIGIT, MONTH_ONES_DIGIT, 2'h0,
    DAY_TENS_DIGIT, DAY_ONES_DIGIT};
  wire [15:0] wh_view = {5'h00, WEEKDAY_DIGIT, 2'h0, HOUR_TENS_DIGIT,
    HOUR_ONES_DIGIT};
  wire md_ok = WDATA[11:8] <= 4'h9 && WDATA[3:0] <= 4'h9;
  wire wh_ok = WDATA[10:8] <= 3'h6 && WDATA[5:4] <= 2'h2 &&
    WDATA[3:0] <= 4'h9;

  always_ff @(posedge CORE_CLK)
    wd_q <= WDATA;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  property p_md_read;
    RD && win && is_md |=> RDATA == md_view;
  endproperty
  a_md_read: assert property (p_md_read)
    else $error("month day view read wrong");
  property p_wh_read;
    RD && win && is_wh |=> RDATA == wh_view;
  endproperty
  a_wh_read: assert property (p_wh_read)
    else $error("weekday hour view read wrong");
  property p_md_write;
    win_wr && CLOCK_WRITE_UNLOCK && is_md && md_ok
      |=> md_view == (wd_q & 16'h1f3f);
  endproperty
  a_md_write: assert property (p_md_write)
    else $error("month day write not stored");
  property p_wh_write;
    win_wr && CLOCK_WRITE_UNLOCK && is_wh && wh_ok
      |=> wh_view == (wd_q & 16'h073f);
  endproperty
  a_wh_write: assert property (p_wh_write)
    else $error("weekday hour write not stored");
  property p_locked;
    win_wr && !CLOCK_WRITE_UNLOCK |=> $stable(md_view) && $stable(wh_view);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked write changed digits");
  property p_other_view;
    win_wr && is_md |=> $stable(wh_view);
  endproperty
  a_other_view: assert property (p_other_view)
    else $error("month day write touched weekday view");
  property p_idle;
    !RD |=> RDATA == 16'h0000;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data not zero outside read");
  property p_range;
    MONTH_ONES_DIGIT <= 4'h9 && DAY_ONES_DIGIT <= 4'h9 &&
      WEEKDAY_DIGIT <= 3'h6 && HOUR_TENS_DIGIT <= 2'h2 &&
      HOUR_ONES_DIGIT <= 4'h9;
  endproperty
  a_range: assert property (p_range)
    else $error("digit out of range");

  cover property (win_wr && CLOCK_WRITE_UNLOCK && is_md && md_ok);
  cover property (win_wr && !CLOCK_WRITE_UNLOCK);
  cover property (RD && win && is_wh);
  cover property (win_wr && CLOCK_WRITE_UNLOCK && is_wh && wh_ok);
endmodule

bind alarm_value_window alarm_value_window_checker chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA),
  .CLOCK_WRITE_UNLOCK(CLOCK_WRITE_UNLOCK),
  .ALARM_VIEW_POINTER(ALARM_VIEW_POINTER),
  .MONTH_TENS_DIGIT(MONTH_TENS_DIGIT), .MONTH_ONES_DIGIT(MONTH_ONES_DIGIT),
  .DAY_TENS_DIGIT(DAY_TENS_DIGIT), .DAY_ONES_DIGIT(DAY_ONES_DIGIT),
  .WEEKDAY_DIGIT(WEEKDAY_DIGIT), .HOUR_TENS_DIGIT(HOUR_TENS_DIGIT),
  .HOUR_ONES_DIGIT(HOUR_ONES_DIGIT));

// ---- tb/alarm_value_window_test.sv ----
`timescale 1ns/1ps
module alarm_value_window_test;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] RDATA;
  logic CLOCK_WRITE_UNLOCK;
  logic [1:0] ALARM_VIEW_POINTER;
  logic MONTH_TENS_DIGIT;
  logic [3:0] MONTH_ONES_DIGIT;
  logic [1:0] DAY_TENS_DIGIT;
  logic [3:0] DAY_ONES_DIGIT;
  logic [2:0] WEEKDAY_DIGIT;
  logic [1:0] HOUR_TENS_DIGIT;
  logic [3:0] HOUR_ONES_DIGIT;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h3f5285a0;
  logic [15:0] md = 16'h0000;
  logic [15:0] wh = 16'h0000;
  logic [15:0] st = 16'h0000;
  logic unlock = 1'b0;
  logic [1:0] ptr = 2'h0;
  logic [15:0] expq[$];
  logic pend = 1'b0;

  alarm_value_window DUT (.CORE_CLK(CORE_CLK), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CLOCK_WRITE_UNLOCK(CLOCK_WRITE_UNLOCK),
    .ALARM_VIEW_POINTER(ALARM_VIEW_POINTER),
    .MONTH_TENS_DIGIT(MONTH_TENS_DIGIT), .MONTH_ONES_DIGIT(MONTH_ONES_DIGIT),
    .DAY_TENS_DIGIT(DAY_TENS_DIGIT), .DAY_ONES_DIGIT(DAY_ONES_DIGIT),
    .WEEKDAY_DIGIT(WEEKDAY_DIGIT), .HOUR_TENS_DIGIT(HOUR_TENS_DIGIT),
    .HOUR_ONES_DIGIT(HOUR_ONES_DIGIT));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xorshift = y ^ (y << 5);
  endfunction

  task automatic close_out;
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // model follows each write: locked, off-view or out-of-range words drop;
  // locked and out-of-range ones raise the matching sticky status flag
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic md_ok;
    logic wh_ok;
    md_ok = d[3:0] <= 4'h9 && d[11:8] <= 4'h9;
    wh_ok = d[3:0] <= 4'h9 && d[10:8] <= 3'h6 && d[5:4] <= 2'h2;
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
    if (a == alarm_pkg::CTRL_OFS)
    begin
      unlock = d[0];
      ptr = d[9:8];
    end
    else if (a == alarm_pkg::STATUS_OFS)
      st = st & ~(d & alarm_pkg::STATUS_MASK);
    else if (a == alarm_pkg::WINDOW_OFS && !unlock)
      st[alarm_pkg::REFUSED_BIT] = 1'b1;
    else if (a == alarm_pkg::WINDOW_OFS && ptr == alarm_pkg::PTR_MONTH_DAY)
    begin
      if (md_ok)
        md = d & alarm_pkg::MD_MASK;
      else
        st[alarm_pkg::RANGE_BIT] = 1'b1;
    end
    else if (a == alarm_pkg::WINDOW_OFS && ptr == alarm_pkg::PTR_WEEKDAY_DIGIT_HOUR)
    begin
      if (wh_ok)
        wh = d & alarm_pkg::WH_MASK;
      else
        st[alarm_pkg::RANGE_BIT] = 1'b1;
    end
  endtask

  task automatic rd(input logic [3:0] a);
    logic [15:0] e;
    e = 16'h0000;
    if (a == alarm_pkg::CTRL_OFS)
      e = {6'h00, ptr, 7'h00, unlock};
    else if (a == alarm_pkg::WINDOW_OFS && ptr == alarm_pkg::PTR_MONTH_DAY)
      e = md;
    else if (a == alarm_pkg::WINDOW_OFS && ptr == alarm_pkg::PTR_WEEKDAY_DIGIT_HOUR)
      e = wh;
    else if (a == alarm_pkg::STATUS_OFS)
      e = st;
    expq.push_back(e);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
  endtask

  initial
  begin
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  // sampled mid-cycle so read data has settled after its edge
  always @(negedge CORE_CLK)
  begin
    if (pend)
    begin
      checks_done++;
      if (expq.size() == 0 || expq[0] !== RDATA)
      begin
        errors++;
        $display("mismatch at %0t: read data %h", $time, RDATA);
      end
      if (expq.size() > 0)
        void'(expq.pop_front());
    end
    if (!RESET)
    begin
      checks_done += 3;
      if ({3'h0, MONTH_TENS_DIGIT, MONTH_ONES_DIGIT, 2'h0, DAY_TENS_DIGIT,
          DAY_ONES_DIGIT} !== md)
      begin
        errors++;
        $display("mismatch at %0t: month and day digits", $time);
      end
      if ({5'h00, WEEKDAY_DIGIT, 2'h0, HOUR_TENS_DIGIT,
          HOUR_ONES_DIGIT} !== wh)
      begin
        errors++;
        $display("mismatch at %0t: weekday and hour digits", $time);
      end
      if ({ALARM_VIEW_POINTER, CLOCK_WRITE_UNLOCK}
          !== {ptr, unlock})
      begin
        errors++;
        $display("mismatch at %0t: unlock or pointer output", $time);
      end
    end
    pend = RD;
    cycles++;
    if (cycles > 4000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (12) @(posedge CORE_CLK);
    RESET <= 1'b0;
    rd(alarm_pkg::CTRL_OFS);
    rd(alarm_pkg::WINDOW_OFS);
    wr(alarm_pkg::CTRL_OFS, 16'h0201);
    wr(alarm_pkg::WINDOW_OFS, 16'hf9f9);
    rd(alarm_pkg::WINDOW_OFS);
    wr(alarm_pkg::WINDOW_OFS, 16'hffff);
    rd(alarm_pkg::WINDOW_OFS);
    wr(alarm_pkg::CTRL_OFS, 16'h0101);
    wr(alarm_pkg::WINDOW_OFS, 16'hfee9);
    rd(alarm_pkg::WINDOW_OFS);
    wr(alarm_pkg::CTRL_OFS, 16'h0100);
    wr(alarm_pkg::WINDOW_OFS, 16'h0000);
    rd(alarm_pkg::WINDOW_OFS);
    rd(alarm_pkg::STATUS_OFS);
    wr(alarm_pkg::STATUS_OFS, 16'h0001);
    rd(alarm_pkg::STATUS_OFS);
    wr(alarm_pkg::CTRL_OFS, 16'h0200);
    rd(alarm_pkg::WINDOW_OFS);
    wr(alarm_pkg::CTRL_OFS, 16'h0300);
    rd(alarm_pkg::WINDOW_OFS);
    wr(4'hc, 16'hffff);
    rd(4'hc);
    rd(alarm_pkg::CTRL_OFS);
    repeat (60)
    begin
      seed = xorshift(seed);
      wr(alarm_pkg::CTRL_OFS, {6'h00, seed[9:8], 7'h00, seed[0] | seed[1]});
      wr(alarm_pkg::WINDOW_OFS, seed[31:16]);
      rd(alarm_pkg::WINDOW_OFS);
      rd(alarm_pkg::STATUS_OFS);
      wr(alarm_pkg::STATUS_OFS, seed[15:0]);
    end
    repeat (3) @(posedge CORE_CLK);
    close_out();
  end
endmodule
